// [src/sar_pkg.sv]
// package for storage attribute, cache control and exception enable block
package sar_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;

    // register index map (word index, byte address is four times)
    localparam logic [5:0] IDX_GUARDED   = 6'h00;
    localparam logic [5:0] IDX_ENDIAN    = 6'h01;
    localparam logic [5:0] IDX_USER      = 6'h02;
    localparam logic [5:0] IDX_CORE_CFG  = 6'h03;
    localparam logic [5:0] IDX_ICACHEABLE = 6'h04;
    localparam logic [5:0] IDX_DCACHEABLE = 6'h05;
    localparam logic [5:0] IDX_WPOLICY   = 6'h06;
    localparam logic [5:0] IDX_VECTOR    = 6'h07;
    localparam logic [5:0] IDX_TIMER_CTL = 6'h08;
    localparam logic [5:0] IDX_MSTATE    = 6'h09;
    localparam logic [5:0] IDX_TB_LOWER  = 6'h0A;
    localparam logic [5:0] IDX_TB_UPPER  = 6'h0B;
    localparam logic [5:0] IDX_CTRL      = 6'h0C;
    localparam logic [5:0] IDX_STATUS    = 6'h0D;
    localparam logic [5:0] IDX_DCC_ADDR  = 6'h0E;

    // reset values
    localparam logic [31:0] RST_GUARDED   = 32'hFFFFFFFF;
    localparam logic [31:0] RST_ZERO      = 32'h00000000;
    localparam logic [31:0] RST_FETCH_PC  = 32'hFFFFFFFC;

    // machine state enable bits
    localparam int MS_CE_BIT = 17;
    localparam int MS_EE_BIT = 15;

    // timer control enable field (low bits), timer event input width
    localparam int TIMER_N = 3;

    // control register command bits
    localparam int CTL_ICINV_BIT  = 0;
    localparam int CTL_DCINV_BIT  = 1;
    localparam int CTL_SYNC_BIT   = 2;

    // core configuration fields
    localparam int CFG_NCREQ_LSB = 0;
    localparam int CFG_NCREQ_W   = 4;
    localparam logic [3:0] CFG_FULL_LINE = 4'h8;

    // data cache geometry
    localparam int DC_SETS     = 256;
    localparam int DC_STRIDE   = 32;
    localparam int DC_SET_W    = 8;
    localparam int DC_OFF_W    = 5;

    // effective attribute set presented to the access path
    typedef struct packed {
        logic [31:0] guarded;
        logic [31:0] endian;
        logic [31:0] user;
        logic [31:0] icacheable;
        logic [31:0] dcacheable;
        logic [31:0] wpolicy;
    } sar_attr_t;

    typedef enum logic [2:0] {
        SAR_ST_IDLE  = 3'b001,
        SAR_ST_ICINV = 3'b010,
        SAR_ST_DCINV = 3'b100
    } sar_state_t;

endpackage : sar_pkg

// [src/sar_core.sv]
// storage attribute, cache control and exception enable registers
//
// Summary of operation
// RL1: reset marks every region guarded
// RL2: software clears guard where not needed
// RL3: reset makes all memory big-endian
// RL4: user-defined attributes disabled after reset
// RL5: core configuration undefined until software writes
// RL6: software enables allocate on every miss
// RL7: software enables cacheable and noncacheable prefetch
// RL8: noncacheable request size set to eight words
// RL9: caches invalidated before enabling them
// RL10: reset clears instruction cacheability
// RL11: reset clears data cacheability
// RL12: per-region write-back or write-through policy
// RL13: internal exceptions always taken, never masked
// RL14: vector prefix forms handler table addresses
// RL15: timer exceptions gated by external enables
// RL16: external exceptions need machine state enables
// RL17: data cache invalidated one class per operation
// RL18: first fetch from top word address
// RL19: time base loaded lower-clear, upper, lower
// RL20: one operation invalidates whole instruction cache
// RL21: attribute writes apply after context sync
`timescale 1ns/1ps
`default_nettype none

module sar_core #(
    parameter int DC_SETS = sar_pkg::DC_SETS
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_reset_n,
    input  wire logic [5:0]              i_addr,
    input  wire logic [31:0]             i_wdata,
    input  wire logic                    i_wr,
    input  wire logic                    i_rd,
    output logic [31:0]                  o_rdata,
    input  wire logic                    i_int_exc,
    input  wire logic                    i_ext_crit,
    input  wire logic                    i_ext_noncrit,
    input  wire logic [2:0]              i_timer_evt,
    output logic                         o_take_internal,
    output logic                         o_take_crit,
    output logic                         o_take_noncrit,
    output logic [31:0]                  o_vector_base,
    output sar_pkg::sar_attr_t           o_attr,
    output logic [31:0]                  o_core_cfg,
    output logic [31:0]                  o_first_fetch,
    output logic                         o_icache_inv,
    output logic                         o_dcache_inv,
    output logic [7:0]                   o_dcache_set
);

    logic [31:0]          guarded_attr_reg;
    logic [31:0]          endian_attr_reg;
    logic [31:0]          user_attr_reg;
    logic [31:0]          core_config_reg;
    logic [31:0]          icache_cacheable_reg;
    logic [31:0]          dcache_cacheable_reg;
    logic [31:0]          dcache_write_policy_reg;
    logic [31:0]          vector_prefix_reg;
    logic [31:0]          timer_control_reg;
    logic [31:0]          machine_state_reg;
    logic [31:0]          time_base_lower;
    logic [31:0]          time_base_upper;
    logic                 cfg_written_reg;
    logic                 ic_valid_reg;
    logic [DC_SETS-1:0]   dc_valid_reg;
    sar_pkg::sar_attr_t   attr_reg;
    sar_pkg::sar_state_t  state_reg;
    logic [7:0]           dc_set_reg;
    logic                 ic_pulse_reg;
    logic                 dc_pulse_reg;
    logic [31:0]          rdata_reg;
    logic                 tb_carry;
    logic [2:0]           timer_hit;

    function automatic logic hit(input logic [5:0] idx);
        hit = i_wr && (i_addr == idx);
    endfunction : hit

    // attribute and configuration registers
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            guarded_attr_reg        <= sar_pkg::RST_GUARDED;  // [RL1]
            endian_attr_reg         <= sar_pkg::RST_ZERO;     // [RL3]
            user_attr_reg           <= sar_pkg::RST_ZERO;     // [RL4]
            core_config_reg         <= sar_pkg::RST_ZERO;
            icache_cacheable_reg    <= sar_pkg::RST_ZERO;     // [RL10]
            dcache_cacheable_reg    <= sar_pkg::RST_ZERO;     // [RL11]
            dcache_write_policy_reg <= sar_pkg::RST_ZERO;
            vector_prefix_reg       <= sar_pkg::RST_ZERO;
            timer_control_reg       <= sar_pkg::RST_ZERO;
            machine_state_reg       <= sar_pkg::RST_ZERO;     // [RL16]
            cfg_written_reg         <= 1'b0;
        end
        else
        begin
            if (hit(sar_pkg::IDX_GUARDED))
                guarded_attr_reg <= i_wdata;
            if (hit(sar_pkg::IDX_ENDIAN))
                endian_attr_reg <= i_wdata;
            if (hit(sar_pkg::IDX_USER))
                user_attr_reg <= i_wdata;
            if (hit(sar_pkg::IDX_CORE_CFG))
            begin
                core_config_reg <= i_wdata;  // [RL5]
                cfg_written_reg <= 1'b1;
            end
            if (hit(sar_pkg::IDX_ICACHEABLE))
                icache_cacheable_reg <= i_wdata;
            if (hit(sar_pkg::IDX_DCACHEABLE))
                dcache_cacheable_reg <= i_wdata;
            if (hit(sar_pkg::IDX_WPOLICY))
                dcache_write_policy_reg <= i_wdata;  // [RL12]
            if (hit(sar_pkg::IDX_VECTOR))
                vector_prefix_reg <= i_wdata;
            if (hit(sar_pkg::IDX_TIMER_CTL))
                timer_control_reg <= i_wdata;
            if (hit(sar_pkg::IDX_MSTATE))
                machine_state_reg <= i_wdata;
        end
    end

    // time base: lower carries into upper
    assign tb_carry = &time_base_lower;
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            time_base_lower <= sar_pkg::RST_ZERO;
            time_base_upper <= sar_pkg::RST_ZERO;
        end
        else
        begin
            if (hit(sar_pkg::IDX_TB_LOWER))
                time_base_lower <= i_wdata;
            else
                time_base_lower <= time_base_lower + 32'h00000001;
            if (hit(sar_pkg::IDX_TB_UPPER))
                time_base_upper <= i_wdata;  // [RL19]
            else if (tb_carry && !hit(sar_pkg::IDX_TB_LOWER))
                time_base_upper <= time_base_upper + 32'h00000001;
        end
    end

    // effective attributes latched on context synchronization
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            attr_reg.guarded    <= sar_pkg::RST_GUARDED;  // [RL1]
            attr_reg.endian     <= sar_pkg::RST_ZERO;     // [RL3]
            attr_reg.user       <= sar_pkg::RST_ZERO;
            attr_reg.icacheable <= sar_pkg::RST_ZERO;
            attr_reg.dcacheable <= sar_pkg::RST_ZERO;
            attr_reg.wpolicy    <= sar_pkg::RST_ZERO;
        end
        else if (hit(sar_pkg::IDX_CTRL) && i_wdata[sar_pkg::CTL_SYNC_BIT])
        begin
            attr_reg.guarded    <= guarded_attr_reg;  // [RL21]
            attr_reg.endian     <= endian_attr_reg;
            attr_reg.user       <= user_attr_reg;
            attr_reg.icacheable <= icache_cacheable_reg;
            attr_reg.dcacheable <= dcache_cacheable_reg;
            attr_reg.wpolicy    <= dcache_write_policy_reg;
        end
    end

    // cache invalidation sequencer
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_reg    <= sar_pkg::SAR_ST_IDLE;
            dc_set_reg   <= 8'h00;
            ic_pulse_reg <= 1'b0;
            dc_pulse_reg <= 1'b0;
        end
        else
        begin
            ic_pulse_reg <= 1'b0;
            dc_pulse_reg <= 1'b0;
            unique case (state_reg)
                sar_pkg::SAR_ST_IDLE:
                begin
                    if (hit(sar_pkg::IDX_CTRL) && i_wdata[sar_pkg::CTL_ICINV_BIT])
                        state_reg <= sar_pkg::SAR_ST_ICINV;
                    else if (hit(sar_pkg::IDX_DCC_ADDR))
                    begin
                        // one congruence class per operation
                        dc_set_reg   <= i_wdata[sar_pkg::DC_OFF_W +: sar_pkg::DC_SET_W];  // [RL17]
                        state_reg    <= sar_pkg::SAR_ST_DCINV;
                    end
                end
                sar_pkg::SAR_ST_ICINV:
                begin
                    ic_pulse_reg <= 1'b1;  // [RL20]
                    state_reg    <= sar_pkg::SAR_ST_IDLE;
                end
                sar_pkg::SAR_ST_DCINV:
                begin
                    dc_pulse_reg <= 1'b1;
                    state_reg    <= sar_pkg::SAR_ST_IDLE;
                end
                default:
                    state_reg <= sar_pkg::SAR_ST_IDLE;
            endcase
        end
    end

    // valid tracking: contents unknown at reset, modelled as valid
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ic_valid_reg <= 1'b1;            // [RL9]
            dc_valid_reg <= '1;
        end
        else
        begin
            if (ic_pulse_reg)
                ic_valid_reg <= 1'b0;        // [RL20]
            if (dc_pulse_reg)
                dc_valid_reg[dc_set_reg] <= 1'b0;  // [RL17]
        end
    end

    // exception gating
    assign timer_hit       = i_timer_evt & timer_control_reg[sar_pkg::TIMER_N-1:0];
    assign o_take_internal = i_int_exc;  // [RL13]
    assign o_take_crit     = machine_state_reg[sar_pkg::MS_CE_BIT]
                             && (i_ext_crit || timer_hit[2]);  // [RL15] [RL16]
    assign o_take_noncrit  = machine_state_reg[sar_pkg::MS_EE_BIT]
                             && (i_ext_noncrit || (|timer_hit[1:0]));  // [RL15] [RL16]
    assign o_vector_base   = vector_prefix_reg;  // [RL14]
    assign o_attr          = attr_reg;
    assign o_core_cfg      = core_config_reg;  // [RL5] [RL8]
    assign o_first_fetch   = sar_pkg::RST_FETCH_PC;  // [RL18]
    assign o_icache_inv    = ic_pulse_reg;
    assign o_dcache_inv    = dc_pulse_reg;
    assign o_dcache_set    = dc_set_reg;

    // read port, data one cycle after strobe
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            rdata_reg <= sar_pkg::RST_ZERO;
        else if (i_rd)
        begin
            unique case (i_addr)
                sar_pkg::IDX_GUARDED:    rdata_reg <= guarded_attr_reg;
                sar_pkg::IDX_ENDIAN:     rdata_reg <= endian_attr_reg;
                sar_pkg::IDX_USER:       rdata_reg <= user_attr_reg;
                sar_pkg::IDX_CORE_CFG:   rdata_reg <= core_config_reg;
                sar_pkg::IDX_ICACHEABLE: rdata_reg <= icache_cacheable_reg;
                sar_pkg::IDX_DCACHEABLE: rdata_reg <= dcache_cacheable_reg;
                sar_pkg::IDX_WPOLICY:    rdata_reg <= dcache_write_policy_reg;
                sar_pkg::IDX_VECTOR:     rdata_reg <= vector_prefix_reg;
                sar_pkg::IDX_TIMER_CTL:  rdata_reg <= timer_control_reg;
                sar_pkg::IDX_MSTATE:     rdata_reg <= machine_state_reg;
                sar_pkg::IDX_TB_LOWER:   rdata_reg <= time_base_lower;
                sar_pkg::IDX_TB_UPPER:   rdata_reg <= time_base_upper;
                sar_pkg::IDX_STATUS:     rdata_reg <= {27'h0000000, cfg_written_reg,
                                                       ic_valid_reg, state_reg};
                sar_pkg::IDX_DCC_ADDR:   rdata_reg <= {16'h0000, 8'h00, dc_set_reg};
                default:                 rdata_reg <= sar_pkg::RST_ZERO;
            endcase
        end
        else
            rdata_reg <= sar_pkg::RST_ZERO;
    end
    assign o_rdata = rdata_reg;

    // reset state of the attribute set
    chk_guard_reset: assert property (@(posedge i_clk)  // [RL1]
        $rose(i_reset_n) |-> o_attr.guarded == sar_pkg::RST_GUARDED)
        else $error("guarded not all set after reset");
    chk_endian_reset: assert property (@(posedge i_clk)  // [RL3] [RL4]
        $rose(i_reset_n) |-> o_attr.endian == sar_pkg::RST_ZERO && o_attr.user == sar_pkg::RST_ZERO)
        else $error("endian or user attr not clear after reset");
    chk_cache_reset: assert property (@(posedge i_clk)  // [RL10] [RL11]
        $rose(i_reset_n) |-> o_attr.icacheable == sar_pkg::RST_ZERO && o_attr.dcacheable == sar_pkg::RST_ZERO)
        else $error("cacheability not clear after reset");

    // attribute set moves only on a sync command
    chk_sync_apply: assert property (@(posedge i_clk) disable iff (!i_reset_n)  // [RL21]
        $changed(o_attr) |-> $past(i_wr && i_addr == sar_pkg::IDX_CTRL && i_wdata[sar_pkg::CTL_SYNC_BIT]))
        else $error("attributes changed without sync");
    chk_sync_copy: assert property (@(posedge i_clk) disable iff (!i_reset_n)  // [RL21] [RL12]
        i_wr && i_addr == sar_pkg::IDX_CTRL && i_wdata[sar_pkg::CTL_SYNC_BIT]
        |=> o_attr.guarded == $past(guarded_attr_reg) && o_attr.wpolicy == $past(dcache_write_policy_reg))
        else $error("sync did not copy the attribute registers");

    // cache invalidation
    chk_ic_inval: assert property (@(posedge i_clk) disable iff (!i_reset_n)  // [RL20]
        i_wr && i_addr == sar_pkg::IDX_CTRL && i_wdata[sar_pkg::CTL_ICINV_BIT] && state_reg == sar_pkg::SAR_ST_IDLE
        |-> ##2 o_icache_inv ##1 !ic_valid_reg)
        else $error("icache invalidate not done in time");
    chk_dc_class: assert property (@(posedge i_clk) disable iff (!i_reset_n)  // [RL17]
        o_dcache_inv |=> !dc_valid_reg[$past(o_dcache_set)])
        else $error("dcache class not invalidated");
    chk_dc_single: assert property (@(posedge i_clk) disable iff (!i_reset_n)  // [RL17]
        o_dcache_inv |=> !o_dcache_inv)
        else $error("dcache invalidate longer than one class");

    // exception gating
    chk_crit_gate: assert property (@(posedge i_clk) disable iff (!i_reset_n)  // [RL16]
        o_take_crit |-> machine_state_reg[sar_pkg::MS_CE_BIT])
        else $error("critical taken while disabled");
    chk_noncrit_take: assert property (@(posedge i_clk) disable iff (!i_reset_n)  // [RL16]
        i_ext_noncrit |-> o_take_noncrit == machine_state_reg[sar_pkg::MS_EE_BIT])
        else $error("noncritical take does not follow its enable");
    chk_timer_gate: assert property (@(posedge i_clk) disable iff (!i_reset_n)  // [RL15]
        (timer_hit[0] && machine_state_reg[sar_pkg::MS_EE_BIT]) |-> o_take_noncrit)
        else $error("enabled timer event not taken");
    chk_internal: assert property (@(posedge i_clk) disable iff (!i_reset_n)  // [RL13]
        i_int_exc |-> o_take_internal)
        else $error("internal exception masked");

    // register port
    chk_vector: assert property (@(posedge i_clk) disable iff (!i_reset_n)  // [RL14]
        i_wr && i_addr == sar_pkg::IDX_VECTOR |=> o_vector_base == $past(i_wdata))
        else $error("vector prefix not loaded");
    chk_core_cfg: assert property (@(posedge i_clk) disable iff (!i_reset_n)  // [RL5] [RL8]
        i_wr && i_addr == sar_pkg::IDX_CORE_CFG |=> cfg_written_reg && o_core_cfg == $past(i_wdata))
        else $error("core configuration not loaded");
    chk_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !$past(i_rd) |-> o_rdata == sar_pkg::RST_ZERO)
        else $error("read data stands without a read");

    cov_ic_inv: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_icache_inv);
    cov_dc_inv: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_dcache_inv);
    cov_sync: cover property (@(posedge i_clk) disable iff (!i_reset_n) $changed(o_attr));
    cov_crit: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_take_crit);
    cov_noncrit: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_take_noncrit);

endmodule : sar_core

`default_nettype wire

// [verification/sar_sw_model.sv]
// initialization software model driving the register port
`timescale 1ns/1ps
`default_nettype none

module sar_sw_model #(
    parameter logic [31:0] CFG_ALLOC_PF = 32'h000000F0 // allocate and prefetch bits
) (
    input  wire logic        i_clk,
    input  wire logic [31:0] i_rdata,
    output logic [5:0]       o_addr,
    output logic [31:0]      o_wdata,
    output logic             o_wr,
    output logic             o_rd
);
    initial
    begin
        o_addr  = 6'h00;
        o_wdata = 32'h00000000;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_wr    <= 1'b1;
        o_addr  <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr    <= 1'b0;
        o_wdata <= ~d; // released data does not keep its last value
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge i_clk);
        o_rd   <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd   <= 1'b0;
        #1;
        d = i_rdata;
    endtask : rd

    task automatic config_core();
        wr(sar_pkg::IDX_CORE_CFG, CFG_ALLOC_PF | {28'h0000000, sar_pkg::CFG_FULL_LINE});
    endtask : config_core

    task automatic inval_icache();
        wr(sar_pkg::IDX_CTRL, 32'h00000001 << sar_pkg::CTL_ICINV_BIT);
    endtask : inval_icache

    task automatic inval_dcache();
        logic [31:0] a;
        a = 32'h00000000;
        for (int k = 0; k < 256; k++)
        begin
            wr(sar_pkg::IDX_DCC_ADDR, a);
            a = a + 32'h00000020;
        end
    endtask : inval_dcache

    task automatic set_attrs(input logic [31:0] g, e, u, ic, dc, wp);
        wr(sar_pkg::IDX_GUARDED, g);
        wr(sar_pkg::IDX_ENDIAN, e);
        wr(sar_pkg::IDX_USER, u);
        wr(sar_pkg::IDX_WPOLICY, wp);
        wr(sar_pkg::IDX_ICACHEABLE, ic);
        wr(sar_pkg::IDX_DCACHEABLE, dc);
    endtask : set_attrs

    task automatic sync();
        wr(sar_pkg::IDX_CTRL, 32'h00000001 << sar_pkg::CTL_SYNC_BIT);
    endtask : sync

    task automatic load_tb(input logic [31:0] up, input logic [31:0] lo);
        wr(sar_pkg::IDX_TB_LOWER, 32'h00000000);
        wr(sar_pkg::IDX_TB_UPPER, up);
        wr(sar_pkg::IDX_TB_LOWER, lo);
    endtask : load_tb
endmodule : sar_sw_model

`default_nettype wire

// [verification/tb_top.sv]
// self-checking testbench for the storage attribute block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic               i_clk;
    logic               i_reset_n;
    logic [5:0]         addr;
    logic [31:0]        wdata;
    logic [31:0]        rdata;
    logic [31:0]        d;
    logic [31:0]        vbase;
    logic [31:0]        cfg;
    logic [31:0]        ffetch;
    logic               wr;
    logic               rd;
    logic               int_exc;
    logic               ext_crit;
    logic               ext_noncrit;
    logic [2:0]         timer_evt;
    logic               t_int;
    logic               t_crit;
    logic               t_nc;
    logic               ic_inv;
    logic               dc_inv;
    logic [7:0]         dc_set;
    sar_pkg::sar_attr_t attr;
    logic [31:0]        ic_cnt;
    logic [31:0]        dc_cnt;
    int                 n_mismatch;
    int                 n_checks;
    logic [5:0]         ridx [8];
    logic [31:0]        rexp [8];

    sar_core sar_core_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_int_exc(int_exc), .i_ext_crit(ext_crit), .i_ext_noncrit(ext_noncrit),
        .i_timer_evt(timer_evt), .o_take_internal(t_int), .o_take_crit(t_crit), .o_take_noncrit(t_nc),
        .o_vector_base(vbase), .o_attr(attr), .o_core_cfg(cfg), .o_first_fetch(ffetch),
        .o_icache_inv(ic_inv), .o_dcache_inv(dc_inv), .o_dcache_set(dc_set));

    sar_sw_model sar_sw_model_inst (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd));

    always #4 i_clk = ~i_clk;

    // invalidate pulse counters
    always @(negedge i_clk)
    begin
        if (ic_inv === 1'b1)
            ic_cnt <= ic_cnt + 32'h00000001;
        if (dc_inv === 1'b1)
            dc_cnt <= dc_cnt + 32'h00000001;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic chk_rd(input logic [5:0] a, input logic [31:0] exp);
        sar_sw_model_inst.rd(a, d);
        chk(d, exp, "read data");
    endtask : chk_rd

    task automatic exc(input logic [31:0] ie, input logic [31:0] c, input logic [31:0] nc);
        @(posedge i_clk);
        #1;
        chk({31'h0, t_int}, ie, "internal take");
        chk({31'h0, t_crit}, c, "critical take");
        chk({31'h0, t_nc}, nc, "noncritical take");
    endtask : exc

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    initial
    begin
        i_clk = 1'b0;
        i_reset_n = 1'b0;
        int_exc = 1'b0;
        ext_crit = 1'b0;
        ext_noncrit = 1'b0;
        timer_evt = 3'h0;
        ic_cnt = 32'h00000000;
        dc_cnt = 32'h00000000;
        n_mismatch = 0;
        n_checks = 0;
        ridx = '{sar_pkg::IDX_GUARDED, sar_pkg::IDX_ENDIAN, sar_pkg::IDX_USER, sar_pkg::IDX_ICACHEABLE,
                 sar_pkg::IDX_DCACHEABLE, sar_pkg::IDX_MSTATE, sar_pkg::IDX_STATUS, 6'h3F};
        rexp = '{32'hFFFFFFFF, 32'h00000000, 32'h00000000, 32'h00000000,
                 32'h00000000, 32'h00000000, 32'h00000009, 32'h00000000};
        repeat (8) @(posedge i_clk);
        i_reset_n <= 1'b1;
        for (int k = 0; k < 8; k++)
            chk_rd(ridx[k], rexp[k]);
        chk_rd(sar_pkg::IDX_GUARDED, 32'hFFFFFFFF);
        @(posedge i_clk);
        #1;
        chk(rdata, 32'h00000000, "idle read data");
        chk(ffetch, 32'hFFFFFFFC, "first fetch");
        chk(attr.guarded, 32'hFFFFFFFF, "guarded out");
        int_exc <= 1'b1;
        ext_crit <= 1'b1;
        ext_noncrit <= 1'b1;
        timer_evt <= 3'h7;
        exc(32'h1, 32'h0, 32'h0);
        sar_sw_model_inst.config_core();
        chk_rd(sar_pkg::IDX_CORE_CFG, 32'h000000F8);
        chk(cfg, 32'h000000F8, "core cfg out");
        chk_rd(sar_pkg::IDX_STATUS, 32'h00000019);
        sar_sw_model_inst.inval_icache();
        for (int k = 0; k < 8 && ic_cnt == 32'h0; k++)
            @(posedge i_clk);
        repeat (4) @(posedge i_clk);
        chk(ic_cnt, 32'h00000001, "icache pulses");
        chk_rd(sar_pkg::IDX_STATUS, 32'h00000011);
        sar_sw_model_inst.inval_dcache();
        repeat (4) @(posedge i_clk);
        chk(dc_cnt, 32'h00000100, "dcache pulses");
        chk({24'h0, dc_set}, 32'h000000FF, "last class");
        chk_rd(sar_pkg::IDX_DCC_ADDR, 32'h000000FF);
        sar_sw_model_inst.set_attrs(32'h0000000F, 32'h00000030, 32'h00000500, 32'h80000000, 32'h40000001,
            32'h0000A000);
        #1;
        chk(attr.guarded, 32'hFFFFFFFF, "guarded before sync");
        chk(attr.icacheable, 32'h00000000, "icacheable before sync");
        chk_rd(sar_pkg::IDX_WPOLICY, 32'h0000A000);
        sar_sw_model_inst.sync();
        #1;
        chk(attr.guarded, 32'h0000000F, "guarded");
        chk(attr.endian, 32'h00000030, "endian");
        chk(attr.user, 32'h00000500, "user");
        chk(attr.icacheable, 32'h80000000, "icacheable");
        chk(attr.dcacheable, 32'h40000001, "dcacheable");
        chk(attr.wpolicy, 32'h0000A000, "write policy");
        sar_sw_model_inst.wr(sar_pkg::IDX_VECTOR, 32'hFFF00000);
        #1;
        chk(vbase, 32'hFFF00000, "vector base");
        sar_sw_model_inst.wr(6'h3F, 32'h12345678);
        chk_rd(6'h3F, 32'h00000000);
        sar_sw_model_inst.load_tb(32'h00000012, 32'h00000100);
        chk_rd(sar_pkg::IDX_TB_UPPER, 32'h00000012);
        sar_sw_model_inst.rd(sar_pkg::IDX_TB_LOWER, d);
        chk({4'h0, d[31:4]}, 32'h00000010, "time base lower");
        sar_sw_model_inst.wr(sar_pkg::IDX_TIMER_CTL, 32'h00000000);
        sar_sw_model_inst.wr(sar_pkg::IDX_MSTATE, 32'h00028000);
        ext_crit <= 1'b0;
        ext_noncrit <= 1'b0;
        exc(32'h1, 32'h0, 32'h0);
        sar_sw_model_inst.wr(sar_pkg::IDX_TIMER_CTL, 32'h00000007);
        exc(32'h1, 32'h1, 32'h1);
        timer_evt <= 3'h1;
        exc(32'h1, 32'h0, 32'h1);
        timer_evt <= 3'h0;
        ext_crit <= 1'b1;
        exc(32'h1, 32'h1, 32'h0);
        sar_sw_model_inst.wr(sar_pkg::IDX_MSTATE, 32'h00008000);
        ext_noncrit <= 1'b1;
        int_exc <= 1'b0;
        exc(32'h0, 32'h0, 32'h1);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
        chk(attr.guarded, 32'hFFFFFFFF, "guarded after reset");
        chk(attr.icacheable | attr.dcacheable, 32'h00000000, "cacheable after reset");
        chk({31'h0, t_nc}, 32'h00000000, "noncritical after reset");
        i_reset_n <= 1'b1;
        repeat (2) @(posedge i_clk);
        end_sim();
    end
endmodule : tb_top

`default_nettype wire
